/* File: mrrs_exec.sv */
`timescale 1ns/1ps
`include "mrrs_params.svh"
module mrrs_exec
   import mrrs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Core state
   output logic global_irq_enable,
   output logic osc_stopped
);

   mrrs_state_t state_q;
   mrrs_op_t op;
   logic [13:0] instr_q;
   logic [12:0] pc_q, stack_top;
   logic [7:0] w_q, option_q, wdt_pre_q, wdt_cnt_q, op_lit, file_rd, alu_a, rot_res, f_wdata;
   logic [6:0] faddr_q, op_addr, f_waddr, f_raddr;
   logic [2:0] sp_q;
   logic [31:0] prdata_q, rd_mux;
   logic [8:0] diff9;
   logic [4:0] diff_nib;
   logic c_q, dc_q, z_q, gie_q, expiry_q, slept_q, osc_q, pready_q, pslverr_q;
   logic tick, busy, acc, wr_ok, exec_go, refuse, mapped, dest_file, rot_c, f_we, s_we;
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign global_irq_enable = gie_q;
   assign osc_stopped = osc_q;

   // ****************************************
   // Instruction fields and decode
   // ****************************************
   assign dest_file = instr_q[7];
   assign op_addr = instr_q[6:0];
   assign op_lit = instr_q[7:0];
   always_comb begin
      op = OP_NOP;
      if (instr_q == `MRRS_OP_IRQ_RETURN) begin
         op = OP_IRQ_RETURN;
      end else if (instr_q == `MRRS_OP_RETURN) begin
         op = OP_RETURN;
      end else if (instr_q == `MRRS_OP_OPTION) begin
         op = OP_OPTION;
      end else if (instr_q == `MRRS_OP_SLEEP) begin
         op = OP_SLEEP;
      end else if (instr_q[13:10] == `MRRS_OP_RETLIT) begin
         op = OP_RETLIT;
      end else if (instr_q[13:9] == `MRRS_OP_SUBLIT) begin
         op = OP_SUBLIT;
      end else if (instr_q[13:8] == `MRRS_OP_ROT_RIGHT) begin
         op = OP_ROT_RIGHT;
      end else if (instr_q[13:8] == `MRRS_OP_ROT_LEFT) begin
         op = OP_ROT_LEFT;
      end else if (instr_q[13:8] == `MRRS_OP_SUBFILE) begin
         op = OP_SUBFILE;
      end
   end

   // ****************************************
   // Arithmetic and rotate
   // ****************************************
   assign alu_a = (op == OP_SUBLIT) ? op_lit : file_rd;
   assign diff9 = {1'b0, alu_a} - {1'b0, w_q};
   assign diff_nib = {1'b0, alu_a[3:0]} - {1'b0, w_q[3:0]};
   assign rot_res = (op == OP_ROT_RIGHT) ? {c_q, file_rd[7:1]} : {file_rd[6:0], c_q};
   assign rot_c = (op == OP_ROT_RIGHT) ? file_rd[0] : file_rd[7];

   // ****************************************
   // APB handshake
   // ****************************************
   assign busy = (state_q != S_IDLE);
   assign acc = psel & penable & ~pready_q;
   assign wr_ok = psel & penable & pready_q & pwrite & ~pslverr_q;
   assign refuse = pwrite & busy & (paddr != `MRRS_OFF_WAKE);
   assign exec_go = (state_q == S_WAIT) & tick;
   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         `MRRS_OFF_INSTR: rd_mux = {18'h0, instr_q};
         `MRRS_OFF_STATUS: rd_mux = {24'h0, osc_q, busy, gie_q, slept_q, expiry_q, z_q, dc_q, c_q};
         `MRRS_OFF_WORK: rd_mux = {24'h0, w_q};
         `MRRS_OFF_OPTION: rd_mux = {24'h0, option_q};
         `MRRS_OFF_PC: rd_mux = {19'h0, pc_q};
         `MRRS_OFF_STACK: rd_mux = {29'h0, sp_q};
         `MRRS_OFF_FADDR: rd_mux = {25'h0, faddr_q};
         `MRRS_OFF_FDATA: rd_mux = {24'h0, file_rd};
         `MRRS_OFF_WDT: rd_mux = {16'h0, wdt_cnt_q, wdt_pre_q};
         `MRRS_OFF_WAKE: rd_mux = 32'h0000_0000;
         default: mapped = 1'b0;
      endcase
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= acc;
         pslverr_q <= acc & (~mapped | refuse);
         if (acc) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
         end
      end
   end

   // ****************************************
   // Sequencer
   // ****************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= S_IDLE;
         instr_q <= 14'h0000;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (wr_ok && paddr == `MRRS_OFF_INSTR) begin
                  instr_q <= pwdata[13:0];
                  state_q <= S_WAIT;
               end
            end
            S_WAIT: begin
               if (tick) begin
                  if (op == OP_IRQ_RETURN || op == OP_RETURN || op == OP_RETLIT) begin
                     state_q <= S_CYC2;
                  end else if (op == OP_SLEEP) begin
                     state_q <= S_SLEEP;
                  end else begin
                     state_q <= S_IDLE;
                  end
               end
            end
            S_CYC2: begin
               if (tick) begin
                  state_q <= S_IDLE;
               end
            end
            S_SLEEP: begin
               if (wr_ok && paddr == `MRRS_OFF_WAKE) begin
                  state_q <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         osc_q <= 1'b0;
      end else if (exec_go && op == OP_SLEEP) begin
         osc_q <= 1'b1;
      end else if (state_q == S_SLEEP && wr_ok && paddr == `MRRS_OFF_WAKE) begin
         osc_q <= 1'b0;
      end
   end

   // ****************************************
   // Working and option registers
   // ****************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         w_q <= `MRRS_RST_WORK;
      end else if (wr_ok && paddr == `MRRS_OFF_WORK) begin
         w_q <= pwdata[7:0];
      end else if (exec_go) begin
         case (op)
            OP_RETLIT: w_q <= op_lit;
            OP_SUBLIT: w_q <= diff9[7:0];
            OP_SUBFILE: if (!dest_file) w_q <= diff9[7:0];
            OP_ROT_RIGHT, OP_ROT_LEFT: if (!dest_file) w_q <= rot_res;
            default: w_q <= w_q;
         endcase
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         option_q <= `MRRS_RST_OPTION;
      end else if (exec_go && op == OP_OPTION) begin
         option_q <= w_q;
      end
   end

   // ****************************************
   // Arithmetic flags and interrupt enable
   // ****************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         c_q <= 1'b0;
         dc_q <= 1'b0;
         z_q <= 1'b0;
      end else if (exec_go && (op == OP_SUBLIT || op == OP_SUBFILE)) begin
         c_q <= ~diff9[8];
         dc_q <= ~diff_nib[4];
         z_q <= (diff9[7:0] == 8'h00);
      end else if (exec_go && (op == OP_ROT_RIGHT || op == OP_ROT_LEFT)) begin
         c_q <= rot_c;
      end else if (wr_ok && paddr == `MRRS_OFF_STATUS) begin
         c_q <= pwdata[`MRRS_ST_C];
         dc_q <= pwdata[`MRRS_ST_DC];
         z_q <= pwdata[`MRRS_ST_Z];
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         gie_q <= 1'b0;
      end else if (exec_go && op == OP_IRQ_RETURN) begin
         gie_q <= 1'b1;
      end else if (wr_ok && paddr == `MRRS_OFF_STATUS) begin
         gie_q <= pwdata[`MRRS_ST_GIE];
      end
   end

   // ****************************************
   // Program counter and return stack
   // ****************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pc_q <= `MRRS_RST_PC;
      end else if (exec_go) begin
         if (op == OP_IRQ_RETURN || op == OP_RETURN || op == OP_RETLIT) begin
            pc_q <= stack_top;
         end else begin
            pc_q <= pc_q + 13'h0001;
         end
      end else if (wr_ok && paddr == `MRRS_OFF_PC) begin
         pc_q <= pwdata[12:0];
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sp_q <= 3'd0;
      end else if (exec_go && (op == OP_IRQ_RETURN || op == OP_RETURN || op == OP_RETLIT)) begin
         sp_q <= sp_q - 3'd1;
      end else if (s_we) begin
         sp_q <= sp_q + 3'd1;
      end
   end
   assign s_we = wr_ok & (paddr == `MRRS_OFF_STACK);
   mrrs_ram #(.AW(3), .DW(13)) u_stack (
      .clk(clk),
      .reset_n(reset_n),
      .we(s_we),
      .waddr(sp_q),
      .wdata(pwdata[12:0]),
      .raddr(sp_q - 3'd1),
      .rdata_q(stack_top)
   );

   // ****************************************
   // Data register file
   // ****************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         faddr_q <= 7'h00;
      end else if (wr_ok && paddr == `MRRS_OFF_FADDR) begin
         faddr_q <= pwdata[6:0];
      end
   end
   always_comb begin
      f_we = 1'b0;
      f_waddr = faddr_q;
      f_wdata = pwdata[7:0];
      if (exec_go && dest_file && (op == OP_SUBFILE || op == OP_ROT_RIGHT || op == OP_ROT_LEFT)) begin
         f_we = 1'b1;
         f_waddr = op_addr;
         f_wdata = (op == OP_SUBFILE) ? diff9[7:0] : rot_res;
      end else if (wr_ok && paddr == `MRRS_OFF_FDATA) begin
         f_we = 1'b1;
      end
   end
   assign f_raddr = busy ? op_addr : ((wr_ok && paddr == `MRRS_OFF_INSTR) ? pwdata[6:0] : faddr_q);
   mrrs_ram #(.AW(7), .DW(8)) u_file (
      .clk(clk),
      .reset_n(reset_n),
      .we(f_we),
      .waddr(f_waddr),
      .wdata(f_wdata),
      .raddr(f_raddr),
      .rdata_q(file_rd)
   );

   // ****************************************
   // Instruction clock and watchdog
   // ****************************************
   mrrs_tick u_tick (
      .clk(clk),
      .reset_n(reset_n),
      .run(~osc_q),
      .tick_q(tick)
   );
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wdt_pre_q <= 8'h00;
         wdt_cnt_q <= 8'h00;
         expiry_q <= `MRRS_RST_EXPIRY;
         slept_q <= `MRRS_RST_SLEPT;
      end else if (exec_go && op == OP_SLEEP) begin
         wdt_pre_q <= 8'h00;
         wdt_cnt_q <= 8'h00;
         expiry_q <= 1'b1;
         slept_q <= 1'b0;
      end else if (tick) begin
         wdt_pre_q <= wdt_pre_q + 8'h01;
         if (wdt_pre_q == `MRRS_WDT_PRE_MAX) begin
            wdt_cnt_q <= wdt_cnt_q + 8'h01;
         end
      end
   end

endmodule

/* File: mrrs_exec_monitor.sv */
`timescale 1ns/1ps
`include "mrrs_params.svh"
module mrrs_exec_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Core state
   input wire logic global_irq_enable,
   input wire logic osc_stopped
);
   // ****************************************
   // Helpers
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   logic done_w;
   logic instr_w;
   assign done_w = psel && penable && pready;
   assign instr_w = done_w && pwrite && !pslverr && paddr == `MRRS_OFF_INSTR;

   // ****************************************
   // Assertions
   // ****************************************
   AST_ONE_WAIT:
   assert property (psel && penable && !pready |=> pready) else $error("pready not after one wait");
   AST_READY_PULSE:
   assert property (pready |=> !pready) else $error("pready longer than one cycle");
   AST_ERR_WITH_READY:
   assert property (pslverr |-> pready) else $error("pslverr without pready");
   AST_UNMAPPED:
   assert property (done_w && paddr > `MRRS_OFF_WAKE |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
   AST_IRQ_RETURN:
   assert property (instr_w && pwdata[13:0] == `MRRS_OP_IRQ_RETURN |-> ##[1:6] global_irq_enable)
      else $error("interrupt return left enable low");
   AST_SLEEP_ENTER:
   assert property (instr_w && pwdata[13:0] == `MRRS_OP_SLEEP |-> ##[1:6] osc_stopped)
      else $error("sleep not entered");
   AST_SLEEP_HOLD:
   assert property (osc_stopped && !(done_w && pwrite && paddr == `MRRS_OFF_WAKE) |=> osc_stopped)
      else $error("sleep left without wake write");
   AST_SLEEP_WDT:
   assert property (done_w && !pwrite && paddr == `MRRS_OFF_WDT && osc_stopped |-> prdata == 32'h0)
      else $error("watchdog not cleared in sleep");
   AST_SLEEP_FLAGS:
   assert property (done_w && !pwrite && paddr == `MRRS_OFF_STATUS && osc_stopped |-> prdata[4:3] == 2'b01)
      else $error("sleep status flags wrong");
   AST_BUSY_REFUSE:
   assert property (done_w && pwrite && osc_stopped && paddr != `MRRS_OFF_WAKE |-> pslverr)
      else $error("write accepted while asleep");
   cover property (instr_w);
   cover property (done_w && pslverr);
   cover property ($rose(global_irq_enable));
   cover property ($rose(osc_stopped));
endmodule

bind mrrs_exec mrrs_exec_monitor mrrs_exec_monitor_i (.clk(clk), .reset_n(reset_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .global_irq_enable(global_irq_enable), .osc_stopped(osc_stopped));

/* File: mrrs_params.svh */
`ifndef MRRS_PARAMS_SVH
`define MRRS_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define MRRS_OFF_INSTR 8'h00
`define MRRS_OFF_STATUS 8'h04
`define MRRS_OFF_WORK 8'h08
`define MRRS_OFF_OPTION 8'h0c
`define MRRS_OFF_PC 8'h10
`define MRRS_OFF_STACK 8'h14
`define MRRS_OFF_FADDR 8'h18
`define MRRS_OFF_FDATA 8'h1c
`define MRRS_OFF_WDT 8'h20
`define MRRS_OFF_WAKE 8'h24

// ****************************************
// Status register bit positions
// ****************************************
`define MRRS_ST_C 0
`define MRRS_ST_DC 1
`define MRRS_ST_Z 2
`define MRRS_ST_EXPIRY 3
`define MRRS_ST_SLEPT 4
`define MRRS_ST_GIE 5
`define MRRS_ST_BUSY 6
`define MRRS_ST_SLEEP 7

// ****************************************
// Reset values
// ****************************************
`define MRRS_RST_WORK 8'h00
`define MRRS_RST_OPTION 8'hff
`define MRRS_RST_PC 13'h0000
`define MRRS_RST_EXPIRY 1'b1
`define MRRS_RST_SLEPT 1'b1

// ****************************************
// Instruction encodings
// ****************************************
`define MRRS_OP_RETURN 14'h0008
`define MRRS_OP_IRQ_RETURN 14'h0009
`define MRRS_OP_OPTION 14'h0062
`define MRRS_OP_SLEEP 14'h0063
`define MRRS_OP_RETLIT 4'b1101
`define MRRS_OP_SUBLIT 5'b11110
`define MRRS_OP_ROT_RIGHT 6'h0c
`define MRRS_OP_ROT_LEFT 6'h0d
`define MRRS_OP_SUBFILE 6'h02

// ****************************************
// Timing
// ****************************************
`define MRRS_TICK_DIV 2'd3
`define MRRS_WDT_PRE_MAX 8'hff

`endif

/* File: mrrs_pkg.sv */
package mrrs_pkg;

   // ****************************************
   // Sequencer states
   // ****************************************
   typedef enum logic [1:0] {
      S_IDLE,
      S_WAIT,
      S_CYC2,
      S_SLEEP
   } mrrs_state_t;

   // ****************************************
   // Decoded operations
   // ****************************************
   typedef enum logic [3:0] {
      OP_NOP,
      OP_IRQ_RETURN,
      OP_RETURN,
      OP_RETLIT,
      OP_OPTION,
      OP_SLEEP,
      OP_ROT_RIGHT,
      OP_ROT_LEFT,
      OP_SUBLIT,
      OP_SUBFILE
   } mrrs_op_t;

endpackage

/* File: mrrs_prog_mem.sv */
`timescale 1ns/1ps
module mrrs_prog_mem (
   // Fetch
   input wire logic [1:0] idx,
   output logic [13:0] word
);
   // ****************************************
   // Return sequence program
   // ****************************************
   always_comb begin
      case (idx)
         2'd0: word = 14'h3642;
         2'd1: word = 14'h0008;
         2'd2: word = 14'h0009;
         default: word = 14'h0000;
      endcase
   end
endmodule

/* File: mrrs_ram.sv */
`timescale 1ns/1ps
module mrrs_ram #(
   parameter int AW = 7,
   parameter int DW = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // Read port
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata_q
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // ****************************************
   // Storage
   // ****************************************
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= mem[raddr];
      end
   end

endmodule

/* File: mrrs_tick.sv */
`timescale 1ns/1ps
`include "mrrs_params.svh"
module mrrs_tick (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Control
   input wire logic run,
   output logic tick_q
);

   logic [1:0] cnt_q;

   // ****************************************
   // Instruction cycle divider
   // ****************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= 2'd0;
         tick_q <= 1'b0;
      end else if (!run) begin
         cnt_q <= 2'd0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (cnt_q == `MRRS_TICK_DIV);
         cnt_q <= (cnt_q == `MRRS_TICK_DIV) ? 2'd0 : cnt_q + 2'd1;
      end
   end

endmodule

/* File: tb_mcu_return_rotate_subtract_exec.sv */
`timescale 1ns/1ps
`include "mrrs_params.svh"
module tb_mcu_return_rotate_subtract_exec;
   // ****************************************
   // Signals
   // ****************************************
   logic clk, reset_n, psel, penable, pwrite, pready, pslverr, global_irq_enable, osc_stopped, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] rom_idx;
   logic [13:0] rom_word;
   int err_total, cmp_count;
   typedef struct {logic [13:0] op; logic [7:0] w; logic [7:0] f; logic [2:0] st;
      logic [7:0] w_x; logic [7:0] f_x; logic [2:0] st_x;} mrrs_row_t;
   mrrs_row_t rows[11] = '{
      '{14'h0c05, 8'h55, 8'he6, 3'b000, 8'h73, 8'he6, 3'b000},
      '{14'h0c85, 8'h55, 8'h01, 3'b001, 8'h55, 8'h80, 3'b001},
      '{14'h0d05, 8'h55, 8'he6, 3'b110, 8'hcc, 8'he6, 3'b111},
      '{14'h0d85, 8'h55, 8'h80, 3'b001, 8'h55, 8'h01, 3'b001},
      '{14'h3c02, 8'h01, 8'h00, 3'b100, 8'h01, 8'h00, 3'b011},
      '{14'h3d02, 8'h02, 8'h00, 3'b000, 8'h00, 8'h00, 3'b111},
      '{14'h3c02, 8'h03, 8'h00, 3'b111, 8'hff, 8'h00, 3'b000},
      '{14'h0285, 8'h02, 8'h03, 3'b100, 8'h02, 8'h01, 3'b011},
      '{14'h0205, 8'h02, 8'h01, 3'b111, 8'hff, 8'h01, 3'b000},
      '{14'h0285, 8'h01, 8'h10, 3'b100, 8'h01, 8'h0f, 3'b001},
      '{14'h0062, 8'ha5, 8'h00, 3'b101, 8'ha5, 8'h00, 3'b101}
   };

   mrrs_exec mrrs_exec_i (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .global_irq_enable(global_irq_enable), .osc_stopped(osc_stopped));
   mrrs_prog_mem mrrs_prog_mem_i (.idx(rom_idx), .word(rom_word));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic chk_bit(input string nm, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %s expected %b seen %b", nm, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d = 32'h0);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) err_total++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic run(input logic [13:0] op);
      int n;
      n = 0;
      apb(1'b1, `MRRS_OFF_INSTR, {18'h0, op});
      do begin
         apb(1'b0, `MRRS_OFF_STATUS);
         n++;
      end while (rd[6] !== 1'b0 && n < 20);
      if (n >= 20) err_total++;
   endtask

   task automatic wrap_up;
      $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      wrap_up;
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      int n;
      reset_n <= 1'b0;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 8'h00;
      pwdata <= 32'h0;
      rom_idx <= 2'd0;
      err_total = 0;
      cmp_count = 0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, `MRRS_OFF_WORK);
      chk("work reset", 32'h0, rd);
      apb(1'b0, `MRRS_OFF_OPTION);
      chk("option reset", 32'hff, rd);
      apb(1'b0, `MRRS_OFF_STATUS);
      chk("status reset", 32'h18, rd);
      chk_bit("irq enable reset", 1'b0, global_irq_enable);
      foreach (rows[i]) begin
         apb(1'b1, `MRRS_OFF_WORK, {24'h0, rows[i].w});
         apb(1'b1, `MRRS_OFF_FADDR, 32'h5);
         apb(1'b1, `MRRS_OFF_FDATA, {24'h0, rows[i].f});
         apb(1'b1, `MRRS_OFF_STATUS, {29'h0, rows[i].st});
         apb(1'b1, `MRRS_OFF_PC, 32'h10);
         run(rows[i].op);
         apb(1'b0, `MRRS_OFF_WORK);
         chk("work", {24'h0, rows[i].w_x}, rd);
         apb(1'b0, `MRRS_OFF_FDATA);
         chk("file", {24'h0, rows[i].f_x}, rd);
         apb(1'b0, `MRRS_OFF_STATUS);
         chk("flags", {24'h0, rows[i].st_x}, {29'h0, rd[2:0]});
         apb(1'b0, `MRRS_OFF_PC);
         chk("pc", 32'h11, rd);
      end
      apb(1'b0, `MRRS_OFF_OPTION);
      chk("option", 32'ha5, rd);
      apb(1'b1, `MRRS_OFF_FADDR, 32'h6);
      run(14'h0c05);
      apb(1'b0, `MRRS_OFF_WORK);
      chk("work far address", 32'h80, rd);
      apb(1'b1, `MRRS_OFF_STACK, 32'h123);
      apb(1'b1, `MRRS_OFF_STACK, 32'h456);
      apb(1'b1, `MRRS_OFF_STACK, 32'h789);
      for (int i = 0; i < 3; i++) begin
         rom_idx <= i[1:0];
         @(posedge clk);
         run(rom_word);
         apb(1'b0, `MRRS_OFF_PC);
         chk("return pc", i == 0 ? 32'h789 : i == 1 ? 32'h456 : 32'h123, rd);
         chk_bit("irq enable", i == 2, global_irq_enable);
      end
      apb(1'b0, `MRRS_OFF_WORK);
      chk("literal", 32'h42, rd);
      apb(1'b0, `MRRS_OFF_STACK);
      chk("stack depth", 32'h0, rd);
      apb(1'b0, `MRRS_OFF_STATUS);
      chk("flags after returns", 32'h4, {29'h0, rd[2:0]});
      apb(1'b1, `MRRS_OFF_INSTR, 32'h63);
      n = 0;
      while (osc_stopped !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      chk_bit("asleep", 1'b1, osc_stopped);
      repeat (20) @(posedge clk);
      apb(1'b0, `MRRS_OFF_WDT);
      chk("watchdog", 32'h0, rd);
      apb(1'b0, `MRRS_OFF_STATUS);
      chk("sleep status", 32'hd, {28'h0, rd[7:6], rd[4:3]});
      apb(1'b1, `MRRS_OFF_WORK, 32'h77);
      chk_bit("write while asleep", 1'b1, err);
      apb(1'b1, `MRRS_OFF_WAKE, 32'h1);
      chk_bit("awake", 1'b0, osc_stopped);
      apb(1'b0, `MRRS_OFF_WORK);
      chk("work kept", 32'h42, rd);
      apb(1'b0, 8'h40);
      chk_bit("unmapped error", 1'b1, err);
      chk("unmapped data", 32'h0, rd);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, `MRRS_OFF_STATUS);
      chk("status second reset", 32'h18, rd);
      chk_bit("irq enable second reset", 1'b0, global_irq_enable);
      wrap_up;
   end
endmodule
